// ===== sbtc_pkg.sv
// Package: shared constants, register map and carrier types of the 16-bit timer/counter.
// Assumes: single clock domain sys_clk, registers on a plain strobe port.
package sbtc_pkg;

  // ==========================================================================
  // Register indices on the plain port
  localparam logic [2:0] ADDR_LOW      = 3'h0;
  localparam logic [2:0] ADDR_HIGH     = 3'h1;
  localparam logic [2:0] ADDR_CONTROL  = 3'h2;
  localparam logic [2:0] ADDR_IRQ_FLAG = 3'h3;
  localparam logic [2:0] ADDR_IRQ_EN   = 3'h4;
  localparam logic [2:0] ADDR_PORT_DIR = 3'h5;
  localparam logic [2:0] ADDR_PORT_IN  = 3'h6;

  // ==========================================================================
  // Control, interrupt flag and pin bit positions
  localparam int CTL_ON_BIT    = 0;
  localparam int CTL_CS_BIT    = 1;
  localparam int CTL_SYNC_BIT  = 2;
  localparam int CTL_OSC_BIT   = 3;
  localparam int CTL_PS_LSB    = 4;
  localparam int IRQ_OVF_BIT   = 0;
  localparam int PIN_OSC_OUT   = 6;
  localparam int PIN_OSC_IN    = 7;

  // ==========================================================================
  // Reset values and count maximum
  localparam logic [7:0]  CONTROL_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [7:0]  PORT_DIR_RST = 8'hFF;
  localparam logic [7:0]  READ_ZERO    = 8'h00;

  // ==========================================================================
  // Instruction cycle is four oscillator clocks
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  typedef struct packed {
    logic [1:0] prescale;
    logic       osc_enable;
    logic       sync_disable;
    logic       clock_select;
    logic       counter_on;
  } sbtc_ctrl_s;

  typedef enum logic [2:0] {
    ARM_IDLE = 3'b001,
    ARM_WAIT = 3'b010,
    ARM_RUN  = 3'b100
  } sbtc_arm_e;

endpackage : sbtc_pkg

// ===== sbtc_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes: input may be asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sbtc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : sbtc_sync
`default_nettype wire

// ===== sbtc_prescale.sv
// Count-clock prescaler: passes one of every 1, 2, 4 or 8 tick pulses.
// Assumes: tick is a one-cycle pulse on sys_clk; clear restarts the division.
`timescale 1ns/1ps
`default_nettype none
module sbtc_prescale (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  input  wire logic       tick,
  output logic            tick_out
);
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic [2:0] mask;
  logic       out_d;
  logic       out_q;

  always_comb begin
    mask  = 3'((4'h1 << ratio) - 4'h1);
    div_d = div_q;
    out_d = 1'b0;
    if (clear) begin
      div_d = 3'h0;
    end else if (tick) begin
      if ((div_q & mask) == mask) begin
        div_d = 3'h0;
        out_d = 1'b1;
      end else begin
        div_d = 3'(div_q + 3'h1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      div_q <= div_d;
      out_q <= out_d;
    end
  end

  assign tick_out = out_q;
endmodule : sbtc_prescale
`default_nettype wire

// ===== sbtc_timer.sv
// Top of the 16-bit timer/counter: register port, count logic, overflow interrupt, pin takeover.
// Assumes: sys_clk 50 MHz as oscillator clock, asynchronous active-high rst,
// register reads return data in the cycle after the read strobe.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 16-bit count in two byte registers
// - Counts up, wraps FFFF to 0000
// - Overflow sets sticky flag bit 0
// - Interrupt forwarded only when enabled
// - Timer and synchronised counter modes
// - Timer mode counts each instruction cycle
// - Counter mode counts rising edges only
// - Counting only while on bit set
// - Special event trigger clears the count
// - Oscillator enable forces pins input, read 0
// - Prescale codes give 1:1 to 1:8
// - Timer clock is oscillator over four
// - Sync bit stored but ignored; counting always synchronised
// - Counter mode needs falling edge before first count
module sbtc_timer (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       special_event,
  input  wire logic       osc_in_pin,
  input  wire logic       osc_out_count_in_pin,
  output logic      [1:0] pin_dir_force,
  output logic            irq
);
  sbtc_pkg::sbtc_ctrl_s ctrl_q, ctrl_d;
  sbtc_pkg::sbtc_arm_e  arm_q, arm_d;
  logic [15:0] count_q, count_d;
  logic [7:0]  port_dir_q, port_dir_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ovf_q, ovf_d;
  logic        ovf_en_q, ovf_en_d;
  logic        irq_q, irq_d;
  logic [1:0]  force_q, force_d;
  logic [1:0]  instr_q, instr_d;
  logic        ext_prev_q, ext_prev_d;
  logic [1:0]  pins_sync;
  logic        ext_level;
  logic        raw_tick;
  logic        count_tick;
  logic        ps_clear;
  logic        wr_low, wr_high, rd_flag;

  // ==========================================================================
  // Pin synchronisers
  sbtc_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({osc_in_pin, osc_out_count_in_pin}),
    .sync_out (pins_sync)
  );

  // ==========================================================================
  // Count source selection
  always_comb begin
    ext_level  = ctrl_q.osc_enable ? pins_sync[1] : pins_sync[0];
    ext_prev_d = ext_level;
    instr_d    = 2'(instr_q + 2'h1);
    raw_tick   = 1'b0;
    arm_d      = arm_q;
    if (!ctrl_q.counter_on) begin
      arm_d = sbtc_pkg::ARM_IDLE;
    end else begin
      case (arm_q)
        sbtc_pkg::ARM_IDLE: begin
          arm_d = sbtc_pkg::ARM_WAIT;
        end
        sbtc_pkg::ARM_WAIT: begin
          if (ext_prev_q && !ext_level) begin
            arm_d = sbtc_pkg::ARM_RUN;
          end
        end
        sbtc_pkg::ARM_RUN: begin
          arm_d = sbtc_pkg::ARM_RUN;
        end
        default: begin
          arm_d = sbtc_pkg::ARM_IDLE;
        end
      endcase
      if (!ctrl_q.clock_select) begin
        raw_tick = (instr_q == sbtc_pkg::INSTR_DIV_LAST);
      end else begin
        raw_tick = (arm_q == sbtc_pkg::ARM_RUN) && !ext_prev_q && ext_level;
      end
    end
  end

  assign ps_clear = !ctrl_q.counter_on || wr_low || wr_high;

  sbtc_prescale u_prescale (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clear    (ps_clear),
    .ratio    (ctrl_q.prescale),
    .tick     (raw_tick),
    .tick_out (count_tick)
  );

  // ==========================================================================
  // Registers, counter and interrupt
  always_comb begin
    wr_low     = reg_wr && (reg_addr == sbtc_pkg::ADDR_LOW);
    wr_high    = reg_wr && (reg_addr == sbtc_pkg::ADDR_HIGH);
    rd_flag    = reg_rd && (reg_addr == sbtc_pkg::ADDR_IRQ_FLAG);
    ctrl_d     = ctrl_q;
    ovf_en_d   = ovf_en_q;
    port_dir_d = port_dir_q;
    count_d    = count_q;
    ovf_d      = ovf_q;
    if (rd_flag) begin
      ovf_d = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        sbtc_pkg::ADDR_CONTROL:  ctrl_d     = reg_wdata[5:0];
        sbtc_pkg::ADDR_IRQ_EN:   ovf_en_d   = reg_wdata[sbtc_pkg::IRQ_OVF_BIT];
        sbtc_pkg::ADDR_PORT_DIR: port_dir_d = reg_wdata;
        default:                 ctrl_d     = ctrl_q;
      endcase
    end
    if (special_event) begin
      count_d = sbtc_pkg::COUNT_RST;
    end else if (count_tick) begin
      count_d = 16'(count_q + 16'h0001);
      if (count_q == sbtc_pkg::COUNT_MAX) begin
        ovf_d = 1'b1;
      end
    end
    if (wr_low) begin
      count_d[7:0] = reg_wdata;
    end
    if (wr_high) begin
      count_d[15:8] = reg_wdata;
    end
    irq_d = ovf_d && ovf_en_d;
    force_d = {2{ctrl_d.osc_enable}};
    rdata_d = sbtc_pkg::READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        sbtc_pkg::ADDR_LOW:      rdata_d = count_q[7:0];
        sbtc_pkg::ADDR_HIGH:     rdata_d = count_q[15:8];
        sbtc_pkg::ADDR_CONTROL:  rdata_d = {2'h0, ctrl_q};
        sbtc_pkg::ADDR_IRQ_FLAG: rdata_d = {7'h00, ovf_q};
        sbtc_pkg::ADDR_IRQ_EN:   rdata_d = {7'h00, ovf_en_q};
        sbtc_pkg::ADDR_PORT_DIR: rdata_d = port_dir_q;
        sbtc_pkg::ADDR_PORT_IN: begin
          rdata_d = ctrl_q.osc_enable ? sbtc_pkg::READ_ZERO : {pins_sync[1], pins_sync[0], 6'h00};
        end
        default: rdata_d = sbtc_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= sbtc_pkg::CONTROL_RST[5:0];
      arm_q      <= sbtc_pkg::ARM_IDLE;
      count_q    <= sbtc_pkg::COUNT_RST;
      port_dir_q <= sbtc_pkg::PORT_DIR_RST;
      rdata_q    <= sbtc_pkg::READ_ZERO;
      ovf_q      <= 1'b0;
      ovf_en_q   <= 1'b0;
      irq_q      <= 1'b0;
      force_q    <= 2'h0;
      instr_q    <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      arm_q      <= arm_d;
      count_q    <= count_d;
      port_dir_q <= port_dir_d;
      rdata_q    <= rdata_d;
      ovf_q      <= ovf_d;
      ovf_en_q   <= ovf_en_d;
      irq_q      <= irq_d;
      force_q    <= force_d;
      instr_q    <= instr_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign irq           = irq_q;
  assign pin_dir_force = force_q;
endmodule : sbtc_timer
`default_nettype wire

// ===== sbtc_monitor.sv
// Port assertions of the timer/counter.
// Assumes: bound to sbtc_timer; one clock, rst async high.
`timescale 1ns/1ps
`default_nettype none
module sbtc_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       special_event,
  input wire logic [1:0] pin_dir_force,
  input wire logic       irq
);
  // ====================
  // Shadow of control and enable
  logic [5:0] ctl_q;
  logic       ien_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 6'h00;
      ien_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == sbtc_pkg::ADDR_CONTROL) ctl_q <= reg_wdata[5:0];
      if (reg_addr == sbtc_pkg::ADDR_IRQ_EN) ien_q <= reg_wdata[0];
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr_low;
    reg_wr && reg_addr == sbtc_pkg::ADDR_LOW && !ctl_q[0] && !special_event;
  endsequence
  sequence s_rd_low;
    reg_rd && reg_addr == sbtc_pkg::ADDR_LOW && !special_event;
  endsequence
  property p_low_load;
    s_wr_low ##1 (!reg_wr && !special_event) ##1 s_rd_low |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  property p_unmapped; reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00; endproperty
  property p_ctl_read;
    reg_rd && reg_addr == sbtc_pkg::ADDR_CONTROL |=> reg_rdata == {2'b00, $past(ctl_q)};
  endproperty
  property p_pin_read;
    reg_rd && reg_addr == sbtc_pkg::ADDR_PORT_IN && ctl_q[3] |=> reg_rdata[7:6] == 2'b00;
  endproperty
  property p_pin_force;
    reg_wr && reg_addr == sbtc_pkg::ADDR_CONTROL ##1 !reg_wr |=> pin_dir_force == {2{$past(reg_wdata[3], 2)}};
  endproperty
  property p_irq_mask; irq |-> ien_q || $past(ien_q); endproperty
  property p_reset_quiet; $fell(rst) |-> !irq && pin_dir_force == 2'b00 && reg_rdata == 8'h00; endproperty
  a_low_load: assert property (p_low_load) else $error("low byte load mismatch");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  a_pin_read: assert property (p_pin_read) else $error("pins not read as zero");
  a_pin_force: assert property (p_pin_force) else $error("pin force wrong");
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not reset");
endmodule : sbtc_monitor
`default_nettype wire

// ===== sbtc_ext_clk.sv
// External count clock source on one pin.
// Assumes: pin stands low between bursts.
`timescale 1ns/1ps
`default_nettype none
module sbtc_ext_clk (
  output var logic pin
);
  initial pin = 1'b0;
  task automatic pulses(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      #(half) pin = 1'b1;
      #(half) pin = 1'b0;
    end
  endtask : pulses
endmodule : sbtc_ext_clk
`default_nettype wire

// ===== test_sixteen_bit_timer_counter.sv
// Testbench of the timer/counter with reference count.
// Assumes: package, design, source and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_sixteen_bit_timer_counter;
  localparam logic [2:0] A_LO = sbtc_pkg::ADDR_LOW;
  localparam logic [2:0] A_HI = sbtc_pkg::ADDR_HIGH;
  localparam logic [2:0] A_CT = sbtc_pkg::ADDR_CONTROL;
  localparam logic [2:0] A_FL = sbtc_pkg::ADDR_IRQ_FLAG;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic special_event = 1'b0;
  logic [7:0] reg_rdata, v, ctl;
  logic [1:0] pin_dir_force;
  logic irq, pin_in, pin_out;
  logic [15:0] d;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 18;
  int cnt;
  always #10 sys_clk = ~sys_clk;
  sbtc_timer sbtc_timer_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_event(special_event),
    .osc_in_pin(pin_in), .osc_out_count_in_pin(pin_out), .pin_dir_force(pin_dir_force), .irq(irq));
  sbtc_ext_clk src_in (.pin(pin_in));
  sbtc_ext_clk src_out (.pin(pin_out));
  // ====================
  // Bus and compare tasks
  task automatic results();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    chk({8'h00, v}, {8'h00, e});
    @(posedge sys_clk);
  endtask : rdc
  // ====================
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rdc(3'(a), (a == 5) ? 8'hFF : 8'h00);
    repeat (4) begin
      d = 16'($random(seed));
      wr(A_HI, d[15:8]);
      wr(A_LO, d[7:0]);
      rdc(A_LO, d[7:0]);
      rdc(A_HI, d[15:8]);
    end
    special_event <= 1'b1;
    @(posedge sys_clk);
    special_event <= 1'b0;
    @(posedge sys_clk);
    rdc(A_LO, 8'h00);
    rdc(A_HI, 8'h00);
    wr(A_LO, 8'hFE);
    wr(A_HI, 8'hFF);
    wr(A_CT, 8'h01);
    repeat (40) @(posedge sys_clk);
    wr(A_CT, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    rdc(A_HI, 8'h00);
    // 42 enabled cycles at one tick per four cycles: FFFE plus 11
    rdc(A_LO, 8'h09);
    chk(16'(v >= 8'h08 && v <= 8'h0A), 16'h0001);
    repeat (6) @(posedge sys_clk);
    rdc(A_LO, 8'h09);
    wr(sbtc_pkg::ADDR_IRQ_EN, 8'h01);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk({15'h0, irq}, 16'h0001);
    if (irq !== 1'b1) results();
    rdc(A_FL, 8'h01);
    rdc(A_FL, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      ctl = 8'(((c >> 1) << 4) | ((c & 1) * 12) | 3);
      wr(A_LO, 8'h00);
      wr(A_HI, 8'h00);
      wr(A_CT, ctl);
      rdc(A_CT, ctl);
      if (c & 1) src_in.pulses(17, 61);
      else src_out.pulses(17, 61);
      repeat (8) @(posedge sys_clk);
      rdc(sbtc_pkg::ADDR_PORT_IN, 8'h00);
      chk({14'h0, pin_dir_force}, (c & 1) ? 16'h0003 : 16'h0000);
      wr(A_CT, 8'h00);
      cnt = 16 >> (c >> 1);
      rdc(A_LO, 8'(cnt));
    end
    src_out.pulses(5, 61);
    @(posedge sys_clk);
    rdc(A_LO, 8'h02);
    results();
  end
endmodule : test_sixteen_bit_timer_counter
bind sbtc_timer sbtc_monitor sbtc_monitor_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .special_event(special_event), .pin_dir_force(pin_dir_force), .irq(irq));
`default_nettype wire
